// file: inc/dsb_pkg.sv
// Behaviour
// - Addresses are taken only on every other rising edge of the primary clock.
// - Write data is taken one word on each rising edge of the true and complement primary clocks.
// - Read data leaves on the output clock pair when supplied, else on the primary pair.
// - A one-bit burst counter loads the low address bit and moves two words per access.
// - With latency select high, read data follows the address by one and a half cycles.
// - With latency select low, read data follows the address by one cycle.
// - Address, control and write data are sampled in registers timed by the primary clocks.
// - Read data passes output registers timed by the output pair, or the primary pair alone.
// - A returned timing pair is driven in tight alignment with the read data.
// - Read and write data share one two-way pin set, and the controller releases it on reads.
// - Writes into the array complete by internal self-timed logic.
// - The array holds 72 megabits, as 4M by 18 or 2M by 36 words.
// - Only rising edges of the primary clocks carry timing.
package dsb_pkg;
  localparam int DSB_DATA_W = 36;
  localparam int DSB_ADDR_W = 21;
  localparam int DSB_FIFO_DEPTH = 32;
  // read latency counted in output half-clock edges after the address edge
  localparam logic [2:0] DSB_LAT_HALF_DDR2 = 3'h3;
  localparam logic [2:0] DSB_LAT_HALF_DDR1 = 3'h2;
  localparam logic [1:0] DSB_KCNT_RST = 2'h2;
  typedef enum logic [1:0] {DSB_WR_IDLE, DSB_WR_W0, DSB_WR_W1} dsb_wr_st_t;
endpackage

// file: design/dsb_fifo.sv
`timescale 1ns/1ns
module dsb_fifo
  import dsb_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = DSB_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  wire push = i_valid && o_ready;
  wire pop = o_valid && i_ready;
  wire [PW-1:0] wr_inc = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [PW-1:0] rd_inc = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  assign o_ready = (count != (PW + 1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data = store[rd_ptr];

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      store[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr <= wr_inc;
      end
      if (pop) begin
        rd_ptr <= rd_inc;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// file: design/dsb_port.sv
`timescale 1ns/1ns
module dsb_port
  import dsb_pkg::*;
#(
  parameter int DATA_W = DSB_DATA_W,
  parameter int ADDR_W = DSB_ADDR_W,
  parameter int FIFO_DEPTH = DSB_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_k,
  input wire logic i_k_n,
  input wire logic i_c,
  input wire logic i_c_n,
  input wire logic i_c_supplied,
  input wire logic i_pll_bypass_select,
  input wire logic i_ld_n,
  input wire logic i_rw,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_dq,
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_returned_timing_pair,
  output logic o_returned_timing_pair_n,
  output logic o_wr_ready
);
  localparam int PW = 8 + ADDR_W + DATA_W;
  localparam int FW = ADDR_W + DATA_W;

  // every pin is foreign to i_clk: two stages before any use
  logic [PW-1:0] pin_s1;
  logic [PW-1:0] pin_s2;
  wire [PW-1:0] pin_raw = {i_k, i_k_n, i_c, i_c_n, i_c_supplied,
    i_pll_bypass_select, i_ld_n, i_rw, i_addr, i_dq};

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else if (i_ce) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  wire k_s = pin_s2[PW-1];
  wire kn_s = pin_s2[PW-2];
  wire c_s = pin_s2[PW-3];
  wire cn_s = pin_s2[PW-4];
  wire csup_s = pin_s2[PW-5];
  wire lat_s = pin_s2[PW-6];
  wire ld_n_s = pin_s2[PW-7];
  wire rw_s = pin_s2[PW-8];
  wire [ADDR_W-1:0] addr_s = pin_s2[DATA_W +: ADDR_W];
  wire [DATA_W-1:0] dq_s = pin_s2[DATA_W-1:0];

  // output timing falls back to the primary pair when C is absent
  wire out_t = csup_s ? c_s : k_s;
  wire out_c = csup_s ? cn_s : kn_s;

  logic k_prev;
  logic kn_prev;
  logic out_t_prev;
  logic out_c_prev;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      k_prev <= 1'b0;
      kn_prev <= 1'b0;
      out_t_prev <= 1'b0;
      out_c_prev <= 1'b0;
    end else if (i_ce) begin
      k_prev <= k_s;
      kn_prev <= kn_s;
      out_t_prev <= out_t;
      out_c_prev <= out_c;
    end
  end

  // falling edges are never looked at
  wire k_rise = k_s && !k_prev;
  wire kn_rise = kn_s && !kn_prev;
  wire hev = (out_t && !out_t_prev) || (out_c && !out_c_prev);

  logic blk;
  wire addr_take = k_rise && !ld_n_s && !blk;
  wire rd_take = addr_take && rw_s;
  wire wr_take = addr_take && !rw_s;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      blk <= 1'b0;
    end else if (i_ce && k_rise) begin
      blk <= addr_take;
    end
  end

  // write side: address edge, then K word, then K-bar word
  dsb_wr_st_t wr_st;
  dsb_wr_st_t next_wr_st;
  logic [ADDR_W-1:0] wr_addr;
  wire w0_push = (wr_st == DSB_WR_W0) && k_rise;
  wire w1_push = (wr_st == DSB_WR_W1) && kn_rise;
  wire fifo_in_valid = w0_push || w1_push;
  wire wr_lsb = wr_addr[0] ^ (wr_st == DSB_WR_W1);
  wire [FW-1:0] fifo_in_data = {wr_addr[ADDR_W-1:1], wr_lsb, dq_s};

  always_comb begin
    next_wr_st = wr_st;
    case (wr_st)
      DSB_WR_IDLE: begin
        if (wr_take) begin
          next_wr_st = DSB_WR_W0;
        end
      end
      DSB_WR_W0: begin
        if (k_rise) begin
          next_wr_st = DSB_WR_W1;
        end
      end
      DSB_WR_W1: begin
        if (kn_rise) begin
          next_wr_st = DSB_WR_IDLE;
        end
      end
      default: begin
        next_wr_st = DSB_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_st <= DSB_WR_IDLE;
      wr_addr <= '0;
    end else if (i_ce) begin
      wr_st <= next_wr_st;
      if (wr_take) begin
        wr_addr <= addr_s;
      end
    end
  end

  // words wait here so the array write never races the pins
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FW-1:0] fifo_out_data;

  dsb_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_valid(fifo_in_valid),
    .o_ready(o_wr_ready),
    .i_data(fifo_in_data),
    .o_valid(fifo_out_valid),
    .i_ready(fifo_out_ready),
    .o_data(fifo_out_data)
  );

  // read fetch: two array cycles right after the address edge
  logic [1:0] fetch_cnt;
  logic fetch_bank;
  logic rd_bank;
  logic [ADDR_W-1:0] rd_base;
  wire fetch_busy = (fetch_cnt != 2'h0);
  wire fetch_lsb = rd_base[0] ^ (fetch_cnt == 2'h2);
  wire [ADDR_W-1:0] mem_addr = fetch_busy ?
    {rd_base[ADDR_W-1:1], fetch_lsb} : fifo_out_data[DATA_W +: ADDR_W];
  // reads win the array; drained writes wait out both fetch cycles
  wire mem_we = fifo_out_valid && !fetch_busy;
  assign fifo_out_ready = mem_we;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fetch_cnt <= 2'h0;
      fetch_bank <= 1'b0;
      rd_bank <= 1'b0;
      rd_base <= '0;
    end else if (i_ce) begin
      if (rd_take) begin
        fetch_cnt <= 2'h1;
        fetch_bank <= rd_bank;
        rd_bank <= !rd_bank;
        rd_base <= addr_s;
      end else if (fetch_busy) begin
        fetch_cnt <= (fetch_cnt == 2'h2) ? 2'h0 : 2'h2;
      end
    end
  end

  // full size is 2**ADDR_W words of DATA_W bits
  logic [DATA_W-1:0] mem [2**ADDR_W];
  wire [DATA_W-1:0] mem_rd = mem[mem_addr];

  always_ff @(posedge i_clk) begin
    if (i_ce && mem_we) begin
      mem[mem_addr] <= fifo_out_data[DATA_W-1:0];
    end
  end

  // two read slots so back-to-back reads can overlap in flight
  wire [2:0] lat_half = lat_s ? DSB_LAT_HALF_DDR2 : DSB_LAT_HALF_DDR1;
  logic [1:0] emit0;
  logic [1:0] emit1;
  logic [DATA_W-1:0] slot_w0 [2];
  logic [DATA_W-1:0] slot_w1 [2];

  for (genvar g = 0; g < 2; g++) begin : g_slot
    logic act;
    logic [2:0] cnt;
    wire [2:0] cnt_inc = cnt + 3'h1;
    wire mine = (fetch_bank == 1'(g));
    assign emit0[g] = act && hev && (cnt_inc == lat_half);
    assign emit1[g] = act && hev && (cnt_inc == lat_half + 3'h1);

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        act <= 1'b0;
        cnt <= 3'h0;
      end else if (i_ce) begin
        if (rd_take && rd_bank == 1'(g)) begin
          act <= 1'b1;
          cnt <= 3'h0;
        end else if (act && hev) begin
          act <= !emit1[g];
          cnt <= cnt_inc;
        end
      end
    end

    always_ff @(posedge i_clk) begin
      if (i_ce && fetch_busy && mine && fetch_cnt == 2'h1) begin
        slot_w0[g] <= mem_rd;
      end
      if (i_ce && fetch_busy && mine && fetch_cnt == 2'h2) begin
        slot_w1[g] <= mem_rd;
      end
    end
  end

  wire emit_any = |{emit0, emit1};
  wire [DATA_W-1:0] emit_word = emit0[0] ? slot_w0[0] :
    emit0[1] ? slot_w0[1] : emit1[0] ? slot_w1[0] : slot_w1[1];

  // data and echo share one register stage for tight alignment
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dq <= '0;
      o_dq_oe <= 1'b0;
      o_returned_timing_pair <= 1'b0;
      o_returned_timing_pair_n <= 1'b0;
    end else if (i_ce) begin
      if (emit_any) begin
        o_dq <= emit_word;
      end
      if (hev) begin
        o_dq_oe <= emit_any;
      end
      o_returned_timing_pair <= out_t;
      o_returned_timing_pair_n <= out_c;
    end
  end

  // helper counters watched only by the checks below
  logic [1:0] kcnt;
  logic [2:0] hcnt;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      kcnt <= DSB_KCNT_RST;
      hcnt <= 3'h0;
    end else if (i_ce) begin
      if (addr_take) begin
        kcnt <= 2'h0;
      end else if (k_rise && kcnt != DSB_KCNT_RST) begin
        kcnt <= kcnt + 2'h1;
      end
      if (rd_take) begin
        hcnt <= 3'h0;
      end else if (hev && hcnt != 3'h7) begin
        hcnt <= hcnt + 3'h1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn || !i_ce);

  addr_alternate_a: assert property (
    addr_take |-> kcnt != 2'h0)
    else $error("address taken on adjacent K edges");
  wr_word_edge_a: assert property (
    fifo_in_valid |-> (k_rise && kcnt == 2'h0) ||
      (kn_rise && kcnt == 2'h1))
    else $error("write word taken off its edge");
  rd_on_outclk_a: assert property (
    (o_dq != $past(o_dq)) |-> $past(hev))
    else $error("read data moved without an output edge");
  lat_ddr2_a: assert property (
    (|emit0) && lat_s |-> hcnt == 3'h2)
    else $error("ddr2 read latency wrong");
  lat_ddr1_a: assert property (
    (|emit0) && !lat_s |-> hcnt == 3'h1)
    else $error("ddr1 read latency wrong");
  burst_pair_a: assert property (
    (|emit0) |-> ##[1:16] (|emit1))
    else $error("second burst word missing");
  echo_align_a: assert property (
    $rose(o_dq_oe) |-> $rose(o_returned_timing_pair) ||
      $rose(o_returned_timing_pair_n))
    else $error("echo clock not aligned with data");
  bus_drive_a: assert property (
    $rose(o_dq_oe) |-> $past(|emit0))
    else $error("bus driven without a read");
  second_lsb_a: assert property (
    fetch_cnt == 2'h2 |-> mem_addr[0] != rd_base[0])
    else $error("second word low bit not inverted");
  self_write_a: assert property (
    fifo_out_valid |-> ##[0:2] mem_we)
    else $error("queued write not drained");

  rd_ddr2_c: cover property ((|emit1) && lat_s);
  rd_ddr1_c: cover property ((|emit1) && !lat_s);
  wr_burst_c: cover property (w0_push ##[1:16] w1_push);
  rd_b2b_c: cover property ((|emit1) ##[1:40] (|emit0));
endmodule

// file: verification/dsb_ctrl_model.sv
`timescale 1ns/1ns
module dsb_ctrl_model #(
  parameter int AW = 6,
  parameter int DW = 36
) (
  input wire logic i_clk,
  output logic o_k,
  output logic o_k_n,
  output logic o_c,
  output logic o_c_n,
  output logic o_ld_n,
  output logic o_rw,
  output logic o_drv,
  output logic [AW-1:0] o_addr,
  output logic [DW-1:0] o_dq
);
  assign o_k_n = ~o_k;
  assign o_c_n = ~o_c;
  // k starts low so reset never releases with k high
  initial begin
    o_k = 1'b0;
    o_ld_n = 1'b1;
    o_rw = 1'b1;
    o_drv = 1'b0;
    o_addr = '0;
    o_dq = '0;
    #41;
    forever begin
      o_k = ~o_k;
      #16;
    end
  end
  // output pair lags a quarter period, so a wrong launch pair shows
  assign #8 o_c = o_k;
  // entered just after a k fall, left just after the next-but-one fall
  task automatic op(input logic go, input logic rd, input logic [AW-1:0] a,
      input logic [DW-1:0] d0, input logic [DW-1:0] d1, input logic dbl);
    o_ld_n = ~go;
    o_rw = rd;
    o_addr = a;
    @(posedge o_k);
    @(negedge i_clk);
    o_ld_n = ~dbl;
    o_rw = 1'b1;
    o_addr = ~a;
    if (go && !rd) begin
      o_drv = 1'b1;
      o_dq = d0;
    end
    @(posedge o_k);
    @(negedge i_clk);
    if (go && !rd) o_dq = d1;
    @(negedge o_k);
    @(negedge i_clk);
    o_drv = 1'b0;
    o_dq = ~o_dq;
  endtask
endmodule

// file: verification/tb_dsb_port.sv
`timescale 1ns/1ns
module tb_dsb_port;
  import dsb_pkg::*;
  localparam int AW = 6;
  localparam int DW = DSB_DATA_W;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic c_sup = 1'b1;
  logic lat = 1'b1;
  logic k, k_n, c, c_n, ld_n, rw, drv, o_dq_oe, e, e_n, o_wr_ready;
  logic pe = 1'b0;
  logic pe_n = 1'b0;
  logic took = 1'b0;
  logic pr = 1'b0;
  logic [AW-1:0] addr;
  logic [DW-1:0] dq_m, i_dq, o_dq;
  logic [DW-1:0] last = '0;
  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] ev [$];
  logic [AW-1:0] wa [$];
  int ei [$];
  int n_mismatch = 0;
  int checked = 0;
  int hcnt = 0;
  time tedge = 0;
  wire sel = c_sup ? c : k;
  wire sel_n = c_sup ? c_n : k_n;
  initial forever #2 i_clk = ~i_clk;
  dsb_ctrl_model #(.AW(AW), .DW(DW)) ctrl (.i_clk(i_clk), .o_k(k),
    .o_k_n(k_n), .o_c(c), .o_c_n(c_n), .o_ld_n(ld_n), .o_rw(rw),
    .o_drv(drv), .o_addr(addr), .o_dq(dq_m));
  dsb_port #(.ADDR_W(AW)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(1'b1),
    .i_k(k), .i_k_n(k_n), .i_c(c), .i_c_n(c_n), .i_c_supplied(c_sup),
    .i_pll_bypass_select(lat), .i_ld_n(ld_n), .i_rw(rw), .i_addr(addr),
    .i_dq(i_dq), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
    .o_returned_timing_pair(e), .o_returned_timing_pair_n(e_n),
    .o_wr_ready(o_wr_ready));
  // an undriven wire must not keep a stale value that could pass for data
  assign i_dq = drv ? dq_m : (o_dq_oe === 1'b1 ? o_dq : ~last);
  always @(posedge i_clk) last <= i_dq;
  task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // the second word of a burst always sits at the partner address
  function automatic logic [AW-1:0] mate(input logic [AW-1:0] a);
    return {a[AW-1:1], ~a[0]};
  endfunction
  // output half-edges from the address edge to burst word w
  function automatic int due(input logic l, input int w);
    return (l ? 3 : 2) + w;
  endfunction
  always @(posedge sel or posedge sel_n) begin
    hcnt++;
    tedge = $time;
  end
  // expectations follow the pins, so a refused address adds nothing
  initial forever begin
    @(posedge k);
    #1;
    if (ld_n === 1'b0 && !took) begin
      took = 1'b1;
      if (rw) begin
        ev.push_back(mem[addr]);
        ev.push_back(mem[mate(addr)]);
        ei.push_back(hcnt + due(lat, 0));
        ei.push_back(hcnt + due(lat, 1));
      end
    end else took = 1'b0;
  end
  always @(negedge i_clk) begin
    pe <= e;
    pe_n <= e_n;
    if (drv && o_dq_oe === 1'b1) check("bus release", 1, 0);
    if (o_dq_oe === 1'b1 && ((e === 1'b1 && pe === 1'b0) ||
        (e_n === 1'b1 && pe_n === 1'b0))) begin
      if (ev.size() == 0) check("extra word", 1, 0);
      else begin
        check("read data", o_dq, ev.pop_front());
        check("latency", hcnt, ei.pop_front());
        check("launch", ($time - tedge) inside {[9:17]}, 1);
      end
    end
  end
  task automatic rst;
    i_rstn = 1'b0;
    repeat (8) @(negedge i_clk);
    check("oe in reset", o_dq_oe, 0);
    check("echo in reset", {e, e_n}, 0);
    check("ready in reset", o_wr_ready, 1);
    @(negedge k);
    @(negedge i_clk);
    i_rstn = 1'b1;
  endtask
  task automatic idle;
    ctrl.op(1'b0, 1'b0, '0, '0, '0, 1'b0);
  endtask
  task automatic rd(input logic [AW-1:0] a);
    ctrl.op(1'b1, 1'b1, a, '0, '0, 1'b0);
    pr = 1'b1;
  endtask
  // a write right after a read would collide with the read burst
  task automatic wr(input logic [AW-1:0] a, input logic dbl);
    logic [63:0] r;
    r = {$urandom(), $urandom()};
    if (pr) idle();
    pr = 1'b0;
    mem[a] = r[DW-1:0];
    mem[mate(a)] = r[63:64-DW];
    wa.push_back(a);
    check("write ready", o_wr_ready, 1);
    ctrl.op(1'b1, 1'b0, a, r[DW-1:0], r[63:64-DW], dbl);
  endtask
  initial begin
    #50000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    logic [AW-1:0] a;
    void'($urandom(57));
    rst();
    wr('0, 1'b0);
    wr('1, 1'b1);
    rd(AW'(1));
    rd('1);
    for (int cfg = 0; cfg < 4; cfg++) begin
      idle();
      idle();
      lat = cfg[0];
      c_sup = cfg[1];
      idle();
      repeat (12) begin
        a = AW'($urandom());
        if (wa.size() > 1 && $urandom() % 2 == 1) begin
          a = wa[$urandom() % (wa.size() - 1)];
          rd({a[AW-1:1], a[0] ^ 1'($urandom())});
        end else wr(a, 1'b0);
      end
    end
    idle();
    idle();
    rst();
    rd(wa[0]);
    idle();
    idle();
    check("words left", ev.size(), 0);
    stop_test();
  end
endmodule
